// ### logic/lpc_pkg.sv
// Shared constants, register layout and carrier types of the low-power mode controller.
package lpc_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [11:0] LPC_CTRL_OFS = 12'h000;
  localparam logic [11:0] LPC_STAT_OFS = 12'h004;

  // Control register field positions.
  localparam int LPC_MSEL_LSB = 0;
  localparam int LPC_WCK_BIT = 3;
  localparam int LPC_RRS_LSB = 4;
  localparam int LPC_FHSI_BIT = 7;
  localparam int LPC_FMSI_BIT = 8;
  localparam int LPC_WPOL_LSB = 9;

  // Status register field positions.
  localparam int LPC_STAT_MODE_LSB = 0;
  localparam int LPC_STAT_CAUSE_LSB = 4;

  // Reset value of the control register.
  localparam logic [31:0] LPC_CTRL_RST = 32'h0000_0000;

  // Mode field codes that select a deep-sleep mode.
  localparam logic [2:0] LPC_MSEL_STOP0 = 3'h0;
  localparam logic [2:0] LPC_MSEL_STOP1 = 3'h1;
  localparam logic [2:0] LPC_MSEL_STOP2 = 3'h2;
  localparam logic [2:0] LPC_MSEL_STOP3 = 3'h3;

  // Retention select patterns for the second SRAM.
  localparam logic [2:0] LPC_RET_NONE = 3'h0;
  localparam logic [2:0] LPC_RET_8K = 3'h1;
  localparam logic [2:0] LPC_RET_FULL = 3'h7;

  // Wake cause codes shown in the status register.
  localparam logic [3:0] LPC_CAUSE_NONE = 4'h0;
  localparam logic [3:0] LPC_CAUSE_IRQ = 4'h1;
  localparam logic [3:0] LPC_CAUSE_EVENT = 4'h2;
  localparam logic [3:0] LPC_CAUSE_EXTLINE = 4'h3;
  localparam logic [3:0] LPC_CAUSE_PIN = 4'h4;
  localparam logic [3:0] LPC_CAUSE_RSTPIN = 4'h5;
  localparam logic [3:0] LPC_CAUSE_RTC = 4'h6;
  localparam logic [3:0] LPC_CAUSE_TAMPER = 4'h7;
  localparam logic [3:0] LPC_CAUSE_I3C = 4'h8;
  localparam logic [3:0] LPC_CAUSE_WDOG = 4'h9;
  localparam logic [3:0] LPC_CAUSE_PERIPH = 4'hA;

  // Operating modes.
  typedef enum logic [2:0] {
    LPC_RUN, LPC_SLEEP, LPC_STOP0, LPC_STOP1, LPC_STOP2, LPC_STOP3, LPC_STBY, LPC_SHDN
  } lpc_mode_t;

  // System clock source to use after a wake-up.
  typedef enum logic [1:0] {
    LPC_CLK_KEEP, LPC_CLK_INT16, LPC_CLK_MULTI_CAP48, LPC_CLK_MULTI_12
  } lpc_clk_sel_t;

  // Clock gates and oscillator enables.
  typedef struct packed {
    logic cpu_clk;
    logic bus_clk;
    logic internal_16mhz_osc;
    logic multispeed_system_osc;
    logic multispeed_kernel_osc;
    logic high_speed_external_osc;
    logic low_speed_internal_osc;
    logic low_speed_external_osc;
  } lpc_osc_t;

  // Regulator, domain and supervisor controls.
  typedef struct packed {
    logic reg_main;
    logic reg_low_power;
    logic main_core_domain_on;
    logic main_core_domain_retain;
    logic always_on_periph_domain_on;
    logic brownout_reset;
    logic supply_monitor;
    logic backup_switch;
    logic [2:0] sram2_retain;
  } lpc_pwr_t;

endpackage

// ### logic/lpc_sync.sv
// Two-stage synchroniser for asynchronous wake-up inputs.
`timescale 1ns/1ps
module lpc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous inputs and their synchronised copies.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // Only the second stage is ever read, so metastability stays inside this module.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ### logic/lpc_ctrl.sv
// Low-power mode controller: mode decode, wake-up gating, clock and power control.
// Summary of operation
// - Sleep stops CPU clock; interrupt wakes, event only after wait-for-event entry.
// - Deep sleep codes 000/001/010 select Stop 0/1/2.
// - Code 011 with deep sleep selects Stop 3.
// - Code 10x, first retain bit only: Standby 8K.
// - Code 10x, all retain bits: Standby full SRAM2.
// - Code 10x, no retain bits: regulators off.
// - Code 11x selects Shutdown, regulators off.
// - Stop 0-2 wake on lines, pins, peripherals.
// - Peripheral interrupt counts as Stop 0-2 wake event.
// - Stop exit clock: 16 MHz or capped multispeed.
// - Stop 0-2 clocks off except low-speed, on request.
// - Stop 0 main regulator, Stop 1 low-power.
// - Stop 2 retains core, keeps peripheral domain.
// - Stop 3 retains core, drops peripheral domain, Standby wake set.
// - Standby: regulator, fast oscillators off, brownout kept.
// - Standby loses state, optional SRAM2 retention.
// - Standby exits on reset pin, watchdog, pins, RTC.
// - Standby exit runs multispeed at 12 MHz.
// - Shutdown drops brownout, monitoring, backup switch.
// - Shutdown keeps only low-speed external oscillator.
// - Shutdown exits on pin, reset, RTC, tamper.
// - Run mode after reset until software selects.
`timescale 1ns/1ps
module lpc_ctrl #(
  parameter int NUM_WAKE_PINS = 2,
  parameter int NUM_EXT_LINES = 16,
  parameter int NUM_PERIPH = 8
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_B,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Core side, same clock.
  input wire logic DEEP_SLEEP_FLAG,
  input wire logic WAIT_FOR_INTERRUPT_ENTRY,
  input wire logic WAIT_FOR_EVENT_ENTRY,
  input wire logic ISR_RETURN,
  input wire logic IRQ_ANY,
  input wire logic WAKE_EVENT,
  output logic CPU_WAKE,
  // Peripheral requests, same clock.
  input wire logic [NUM_PERIPH-1:0] PERIPH_IRQ,
  input wire logic AUTO_HSI_REQ,
  input wire logic AUTO_MSI_REQ,
  // Asynchronous wake-up sources.
  input wire logic [NUM_EXT_LINES-1:0] EXTERNAL_EVENT_LINES,
  input wire logic [NUM_WAKE_PINS-1:0] WAKE_PINS,
  input wire logic EXTERNAL_RESET_PIN_B,
  input wire logic RTC_EVENT,
  input wire logic TAMPER_EVENT,
  input wire logic I3C_RESET_PATTERN,
  input wire logic WATCHDOG_EARLY_WAKE,
  input wire logic WATCHDOG_RESET,
  // Clock, power and status outputs.
  output lpc_pkg::lpc_osc_t OSC_EN,
  output lpc_pkg::lpc_pwr_t PWR_CTRL,
  output lpc_pkg::lpc_clk_sel_t WAKE_CLK,
  output lpc_pkg::lpc_mode_t MODE,
  output logic SYS_RESET_REQ
);

  localparam int NA = 6 + NUM_WAKE_PINS + NUM_EXT_LINES;

  ////////////////////////////////////////////////////////////////////////////////
  // Wake source synchronisation and pin edge detection.

  logic [NA-1:0] async_raw;
  logic [NA-1:0] async_s;
  logic [NUM_WAKE_PINS-1:0] pins_prev;
  logic [NUM_WAKE_PINS-1:0] wake_pin_pol;
  wire [NUM_WAKE_PINS-1:0] pins_s = async_s[6 +: NUM_WAKE_PINS];
  wire [NUM_EXT_LINES-1:0] ext_s = async_s[6 + NUM_WAKE_PINS +: NUM_EXT_LINES];
  wire rst_pin_wake = ~async_s[0];
  wire rtc_wake = async_s[1];
  wire tamper_wake = async_s[2];
  wire i3c_wake = async_s[3];
  wire wdog_wake = async_s[4] | async_s[5];

  // All pin-level sources share one synchroniser bank.
  assign async_raw = {EXTERNAL_EVENT_LINES, WAKE_PINS, WATCHDOG_RESET, WATCHDOG_EARLY_WAKE,
                      I3C_RESET_PATTERN, TAMPER_EVENT, RTC_EVENT, EXTERNAL_RESET_PIN_B};

  lpc_sync #(.W(NA)) u_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .d(async_raw),
    .q(async_s)
  );

  // Previous pin level, taken from the synchronised copy only.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pins_prev <= '0;
    end else begin
      pins_prev <= pins_s;
    end
  end

  // A polarity bit of one selects the falling edge for that pin.
  wire [NUM_WAKE_PINS-1:0] pin_rise = pins_s & ~pins_prev;
  wire [NUM_WAKE_PINS-1:0] pin_fall = ~pins_s & pins_prev;
  wire pin_edge = |((pin_rise & ~wake_pin_pol) | (pin_fall & wake_pin_pol));

  ////////////////////////////////////////////////////////////////////////////////
  // APB register file.

  logic [2:0] low_power_mode_select;
  logic stop_wake_clock_select;
  logic sram2_retain_sel_a;
  logic sram2_retain_sel_b;
  logic sram2_retain_sel_c;
  logic force_hsi_on;
  logic force_msi_on;
  logic [3:0] wake_cause;
  lpc_pkg::lpc_mode_t mode;

  wire hit_ctrl = PADDR == lpc_pkg::LPC_CTRL_OFS;
  wire hit_stat = PADDR == lpc_pkg::LPC_STAT_OFS;
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_access = PSEL & PENABLE;
  wire ctrl_write = apb_access & PWRITE & hit_ctrl;
  wire [2:0] rrs = {sram2_retain_sel_c, sram2_retain_sel_b, sram2_retain_sel_a};

  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] read_mux;

  // Assemble readable words; unused bits read as zero.
  always_comb begin
    ctrl_word = '0;
    ctrl_word[lpc_pkg::LPC_MSEL_LSB +: 3] = low_power_mode_select;
    ctrl_word[lpc_pkg::LPC_WCK_BIT] = stop_wake_clock_select;
    ctrl_word[lpc_pkg::LPC_RRS_LSB +: 3] = rrs;
    ctrl_word[lpc_pkg::LPC_FHSI_BIT] = force_hsi_on;
    ctrl_word[lpc_pkg::LPC_FMSI_BIT] = force_msi_on;
    ctrl_word[lpc_pkg::LPC_WPOL_LSB +: NUM_WAKE_PINS] = wake_pin_pol;
    stat_word = '0;
    stat_word[lpc_pkg::LPC_STAT_MODE_LSB +: 3] = mode;
    stat_word[lpc_pkg::LPC_STAT_CAUSE_LSB +: 4] = wake_cause;
  end

  assign read_mux = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0000_0000);
  // Zero wait states; an unmapped address answers with an error.
  assign PREADY = 1'b1;
  assign PSLVERR = apb_access & ~hit_ctrl & ~hit_stat;

  // Read data is captured in the setup cycle so it comes from a flop.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h0000_0000;
    end else if (apb_setup && !PWRITE) begin
      PRDATA <= read_mux;
    end
  end

  // Control register; status is read-only, writes to it are ignored.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      low_power_mode_select <= lpc_pkg::LPC_CTRL_RST[lpc_pkg::LPC_MSEL_LSB +: 3];
      stop_wake_clock_select <= lpc_pkg::LPC_CTRL_RST[lpc_pkg::LPC_WCK_BIT];
      {sram2_retain_sel_c, sram2_retain_sel_b, sram2_retain_sel_a} <=
        lpc_pkg::LPC_CTRL_RST[lpc_pkg::LPC_RRS_LSB +: 3];
      force_hsi_on <= lpc_pkg::LPC_CTRL_RST[lpc_pkg::LPC_FHSI_BIT];
      force_msi_on <= lpc_pkg::LPC_CTRL_RST[lpc_pkg::LPC_FMSI_BIT];
      wake_pin_pol <= lpc_pkg::LPC_CTRL_RST[lpc_pkg::LPC_WPOL_LSB +: NUM_WAKE_PINS];
    end else if (ctrl_write) begin
      low_power_mode_select <= PWDATA[lpc_pkg::LPC_MSEL_LSB +: 3];
      stop_wake_clock_select <= PWDATA[lpc_pkg::LPC_WCK_BIT];
      {sram2_retain_sel_c, sram2_retain_sel_b, sram2_retain_sel_a} <=
        PWDATA[lpc_pkg::LPC_RRS_LSB +: 3];
      force_hsi_on <= PWDATA[lpc_pkg::LPC_FHSI_BIT];
      force_msi_on <= PWDATA[lpc_pkg::LPC_FMSI_BIT];
      wake_pin_pol <= PWDATA[lpc_pkg::LPC_WPOL_LSB +: NUM_WAKE_PINS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Entry decode and wake-up qualification.

  lpc_pkg::lpc_mode_t deep_mode;
  lpc_pkg::lpc_mode_t entry_mode;
  lpc_pkg::lpc_mode_t next_mode;
  lpc_pkg::lpc_clk_sel_t next_wake_clk;
  logic [2:0] ret_sel;
  logic sleep_by_event;
  logic wake;
  logic [3:0] next_cause;

  wire entry = (WAIT_FOR_INTERRUPT_ENTRY | WAIT_FOR_EVENT_ENTRY | ISR_RETURN)
               & (mode == lpc_pkg::LPC_RUN);
  wire periph_wake = |PERIPH_IRQ;
  wire stop_wake = IRQ_ANY | periph_wake | (|ext_s) | pin_edge | i3c_wake;
  wire shdn_wake = rst_pin_wake | pin_edge | rtc_wake | tamper_wake | i3c_wake;
  wire stby_wake = shdn_wake | wdog_wake;
  wire sleep_wake = IRQ_ANY | (sleep_by_event & WAKE_EVENT);
  wire leaving_lost = wake & ((mode == lpc_pkg::LPC_STBY) | (mode == lpc_pkg::LPC_SHDN));

  // Mode field decode; the low bit is ignored for Standby and Shutdown.
  always_comb begin
    unique case (low_power_mode_select)
      lpc_pkg::LPC_MSEL_STOP0: deep_mode = lpc_pkg::LPC_STOP0;
      lpc_pkg::LPC_MSEL_STOP1: deep_mode = lpc_pkg::LPC_STOP1;
      lpc_pkg::LPC_MSEL_STOP2: deep_mode = lpc_pkg::LPC_STOP2;
      lpc_pkg::LPC_MSEL_STOP3: deep_mode = lpc_pkg::LPC_STOP3;
      3'h4, 3'h5: deep_mode = lpc_pkg::LPC_STBY;
      3'h6, 3'h7: deep_mode = lpc_pkg::LPC_SHDN;
    endcase
  end

  // Fields are sampled at the entry instant, so they must be set up beforehand.
  assign entry_mode = DEEP_SLEEP_FLAG ? deep_mode : lpc_pkg::LPC_SLEEP;

  // Per-mode wake qualification; Stop 3 only honours the Standby set.
  always_comb begin
    unique case (mode)
      lpc_pkg::LPC_RUN: wake = 1'b0;
      lpc_pkg::LPC_SLEEP: wake = sleep_wake;
      lpc_pkg::LPC_STOP0, lpc_pkg::LPC_STOP1, lpc_pkg::LPC_STOP2: wake = stop_wake;
      lpc_pkg::LPC_STOP3: wake = stby_wake;
      lpc_pkg::LPC_STBY: wake = stby_wake;
      lpc_pkg::LPC_SHDN: wake = shdn_wake;
    endcase
  end

  // Wake cause by fixed priority: resets first, then core, then peripherals.
  always_comb begin
    if (mode != lpc_pkg::LPC_SLEEP && mode != lpc_pkg::LPC_STOP0 && mode != lpc_pkg::LPC_STOP1
        && mode != lpc_pkg::LPC_STOP2 && rst_pin_wake) begin
      next_cause = lpc_pkg::LPC_CAUSE_RSTPIN;
    end else if (mode != lpc_pkg::LPC_SHDN && (mode == lpc_pkg::LPC_STOP3
                 || mode == lpc_pkg::LPC_STBY) && wdog_wake) begin
      next_cause = lpc_pkg::LPC_CAUSE_WDOG;
    end else if (mode != lpc_pkg::LPC_STOP3 && mode != lpc_pkg::LPC_STBY
                 && mode != lpc_pkg::LPC_SHDN && IRQ_ANY) begin
      next_cause = lpc_pkg::LPC_CAUSE_IRQ;
    end else if (mode == lpc_pkg::LPC_SLEEP) begin
      next_cause = lpc_pkg::LPC_CAUSE_EVENT;
    end else if (pin_edge) begin
      next_cause = lpc_pkg::LPC_CAUSE_PIN;
    end else if (i3c_wake) begin
      next_cause = lpc_pkg::LPC_CAUSE_I3C;
    end else if ((mode == lpc_pkg::LPC_STOP3 || mode == lpc_pkg::LPC_STBY
                  || mode == lpc_pkg::LPC_SHDN) && rtc_wake) begin
      next_cause = lpc_pkg::LPC_CAUSE_RTC;
    end else if (mode == lpc_pkg::LPC_STOP3 || mode == lpc_pkg::LPC_STBY
                 || mode == lpc_pkg::LPC_SHDN) begin
      next_cause = lpc_pkg::LPC_CAUSE_TAMPER;
    end else if (periph_wake) begin
      next_cause = lpc_pkg::LPC_CAUSE_PERIPH;
    end else begin
      next_cause = lpc_pkg::LPC_CAUSE_EXTLINE;
    end
  end

  // Next mode and the clock to run from after leaving it.
  always_comb begin
    next_mode = mode;
    next_wake_clk = WAKE_CLK;
    if (entry) begin
      next_mode = entry_mode;
    end else if (wake) begin
      next_mode = lpc_pkg::LPC_RUN;
      unique case (mode)
        lpc_pkg::LPC_SLEEP: next_wake_clk = lpc_pkg::LPC_CLK_KEEP;
        lpc_pkg::LPC_STBY, lpc_pkg::LPC_SHDN: next_wake_clk = lpc_pkg::LPC_CLK_MULTI_12;
        default: next_wake_clk = stop_wake_clock_select ? lpc_pkg::LPC_CLK_INT16
                                                        : lpc_pkg::LPC_CLK_MULTI_CAP48;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode state and wake bookkeeping.

  // Reset always lands in Run; only software entry leaves it.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode <= lpc_pkg::LPC_RUN;
      WAKE_CLK <= lpc_pkg::LPC_CLK_KEEP;
      sleep_by_event <= 1'b0;
      ret_sel <= lpc_pkg::LPC_RET_NONE;
      wake_cause <= lpc_pkg::LPC_CAUSE_NONE;
      CPU_WAKE <= 1'b0;
      SYS_RESET_REQ <= 1'b0;
    end else begin
      mode <= next_mode;
      WAKE_CLK <= next_wake_clk;
      CPU_WAKE <= wake;
      SYS_RESET_REQ <= leaving_lost;
      if (entry) begin
        sleep_by_event <= WAIT_FOR_EVENT_ENTRY;
        ret_sel <= rrs;
      end
      if (wake) begin
        wake_cause <= next_cause;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and power controls, registered from the current mode.

  lpc_pkg::lpc_osc_t next_osc;
  lpc_pkg::lpc_pwr_t next_pwr;
  wire stby_keep = |ret_sel;

  // Each mode's clock and supply picture; the Run picture allows everything.
  always_comb begin
    next_osc = '1;
    next_pwr = '0;
    next_pwr.reg_main = 1'b1;
    next_pwr.main_core_domain_on = 1'b1;
    next_pwr.always_on_periph_domain_on = 1'b1;
    next_pwr.brownout_reset = 1'b1;
    next_pwr.supply_monitor = 1'b1;
    next_pwr.backup_switch = 1'b1;
    unique case (mode)
      lpc_pkg::LPC_RUN: next_osc.cpu_clk = 1'b1;
      lpc_pkg::LPC_SLEEP: next_osc.cpu_clk = 1'b0;
      lpc_pkg::LPC_STOP0, lpc_pkg::LPC_STOP1, lpc_pkg::LPC_STOP2: begin
        next_osc.cpu_clk = 1'b0;
        next_osc.bus_clk = 1'b0;
        next_osc.high_speed_external_osc = 1'b0;
        next_osc.internal_16mhz_osc = AUTO_HSI_REQ | force_hsi_on;
        next_osc.multispeed_system_osc = AUTO_MSI_REQ | force_msi_on;
        next_osc.multispeed_kernel_osc = AUTO_MSI_REQ | force_msi_on;
        next_pwr.reg_main = (mode == lpc_pkg::LPC_STOP0);
        next_pwr.reg_low_power = (mode != lpc_pkg::LPC_STOP0);
        next_pwr.main_core_domain_retain = (mode == lpc_pkg::LPC_STOP2);
      end
      lpc_pkg::LPC_STOP3: begin
        next_osc[6:2] = 5'h00;
        next_osc.cpu_clk = 1'b0;
        next_pwr.reg_main = 1'b0;
        next_pwr.reg_low_power = 1'b1;
        next_pwr.main_core_domain_retain = 1'b1;
        next_pwr.always_on_periph_domain_on = 1'b0;
        next_pwr.supply_monitor = 1'b0;
      end
      lpc_pkg::LPC_STBY: begin
        next_osc[7:2] = 6'h00;
        next_pwr.reg_main = 1'b0;
        next_pwr.reg_low_power = stby_keep;
        next_pwr.main_core_domain_on = 1'b0;
        next_pwr.always_on_periph_domain_on = 1'b0;
        next_pwr.supply_monitor = 1'b0;
        next_pwr.sram2_retain = ret_sel;
      end
      lpc_pkg::LPC_SHDN: begin
        next_osc[7:1] = 7'h00;
        next_pwr = '0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      OSC_EN <= '1;
      PWR_CTRL <= '0;
    end else begin
      OSC_EN <= next_osc;
      PWR_CTRL <= next_pwr;
    end
  end

  assign MODE = mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_light_entry;
    entry && !DEEP_SLEEP_FLAG;
  endsequence
  sequence s_sleep_gated;
    mode == lpc_pkg::LPC_SLEEP ##1 !OSC_EN.cpu_clk && OSC_EN.bus_clk;
  endsequence

  property p_sleep;
    s_light_entry |=> s_sleep_gated;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep entry did not gate CPU clock");

  property p_stop_decode;
    entry && DEEP_SLEEP_FLAG && !low_power_mode_select[2] |=>
      mode == lpc_pkg::lpc_mode_t'({1'b0, $past(low_power_mode_select[1:0])} + 3'h2);
  endproperty
  a_stop_decode: assert property (p_stop_decode) else $error("Stop code misdecoded");

  property p_stop3;
    entry && DEEP_SLEEP_FLAG && low_power_mode_select == lpc_pkg::LPC_MSEL_STOP3 |=>
      mode == lpc_pkg::LPC_STOP3 ##1 PWR_CTRL.reg_low_power && !OSC_EN.internal_16mhz_osc;
  endproperty
  a_stop3: assert property (p_stop3) else $error("Stop 3 entry wrong");

  property p_stby_8k;
    entry && DEEP_SLEEP_FLAG && low_power_mode_select[2:1] == 2'b10 && rrs == lpc_pkg::LPC_RET_8K
      |=> ##1 PWR_CTRL.sram2_retain == lpc_pkg::LPC_RET_8K && PWR_CTRL.reg_low_power;
  endproperty
  a_stby_8k: assert property (p_stby_8k) else $error("Standby 8K retention wrong");

  property p_stby_full;
    entry && DEEP_SLEEP_FLAG && low_power_mode_select[2:1] == 2'b10
      && rrs == lpc_pkg::LPC_RET_FULL |=> ##1 PWR_CTRL.sram2_retain == lpc_pkg::LPC_RET_FULL;
  endproperty
  a_stby_full: assert property (p_stby_full) else $error("Standby full retention wrong");

  property p_stby_off;
    mode == lpc_pkg::LPC_STBY && ret_sel == lpc_pkg::LPC_RET_NONE |=>
      !PWR_CTRL.reg_main && !PWR_CTRL.reg_low_power && PWR_CTRL.brownout_reset;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("Standby regulators not off");

  property p_shdn;
    entry && DEEP_SLEEP_FLAG && low_power_mode_select[2:1] == 2'b11 |=>
      mode == lpc_pkg::LPC_SHDN ##1 !PWR_CTRL.brownout_reset && OSC_EN == 8'h01;
  endproperty
  a_shdn: assert property (p_shdn) else $error("Shutdown entry wrong");

  property p_periph_wake;
    (mode == lpc_pkg::LPC_STOP1 || mode == lpc_pkg::LPC_STOP2) && |PERIPH_IRQ |=>
      mode == lpc_pkg::LPC_RUN && CPU_WAKE;
  endproperty
  a_periph_wake: assert property (p_periph_wake) else $error("Peripheral wake lost");

  property p_stop_clk;
    wake && (mode inside {lpc_pkg::LPC_STOP0, lpc_pkg::LPC_STOP1, lpc_pkg::LPC_STOP2,
      lpc_pkg::LPC_STOP3}) && stop_wake_clock_select |=> WAKE_CLK == lpc_pkg::LPC_CLK_INT16;
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("Stop wake clock wrong");

  property p_stby_exit;
    mode == lpc_pkg::LPC_STBY && rst_pin_wake |=>
      SYS_RESET_REQ && WAKE_CLK == lpc_pkg::LPC_CLK_MULTI_12 ##1 !SYS_RESET_REQ;
  endproperty
  a_stby_exit: assert property (p_stby_exit) else $error("Standby exit wrong");

endmodule

// ### tb/lpc_core_mdl.sv
// Core model that turns a one-cycle request into one sleep-entry pulse.
`timescale 1ns/1ps
module lpc_core_mdl (
  // Clock and request.
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] kind,
  // Entry pulses.
  output logic wait_int = 1'b0,
  output logic wait_evt = 1'b0,
  output logic isr = 1'b0
);
  // Pulses come only after the bench has written the mode fields.
  always @(posedge clk) begin
    wait_int <= go && kind == 2'h0;
    wait_evt <= go && kind == 2'h1;
    isr <= go && kind == 2'h2;
  end
endmodule

// ### tb/low_power_mode_controller_tb.sv
// Self-checking testbench of the low-power mode controller.
`timescale 1ns/1ps
module low_power_mode_controller_tb;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pw = 1'b0, deep = 1'b0, go = 1'b0;
  logic irq = 1'b0, evt = 1'b0, rtc = 1'b0, tmp = 1'b0, wdw = 1'b0, wdr = 1'b0, ahr = 1'b0;
  logic [1:0] kind = 2'h0, pin = 2'h0;
  logic rpb = 1'b1;
  logic [11:0] pa = 12'h000;
  logic [31:0] wd = 32'h0, rd, prd;
  logic [7:0] pirq = 8'h00;
  logic prdy, perr, e, wint, wevt, isr, cw, srr;
  logic [2:0] rs [3] = '{3'h1, 3'h7, 3'h0};
  lpc_pkg::lpc_osc_t osc;
  lpc_pkg::lpc_pwr_t pc;
  lpc_pkg::lpc_clk_sel_t wck;
  lpc_pkg::lpc_mode_t mode;
  int n_errors = 0, checks_done = 0, cyc = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, design and core model.
  always #12.5 clk = ~clk;
  lpc_ctrl uut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen), .PWRITE(pw),
    .PADDR(pa), .PWDATA(wd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .DEEP_SLEEP_FLAG(deep), .WAIT_FOR_INTERRUPT_ENTRY(wint), .WAIT_FOR_EVENT_ENTRY(wevt),
    .ISR_RETURN(isr), .IRQ_ANY(irq), .WAKE_EVENT(evt), .CPU_WAKE(cw), .PERIPH_IRQ(pirq),
    .AUTO_HSI_REQ(ahr), .AUTO_MSI_REQ(1'b0), .EXTERNAL_EVENT_LINES(16'h0000),
    .WAKE_PINS(pin), .EXTERNAL_RESET_PIN_B(rpb), .RTC_EVENT(rtc), .TAMPER_EVENT(tmp),
    .I3C_RESET_PATTERN(1'b0), .WATCHDOG_EARLY_WAKE(wdw), .WATCHDOG_RESET(wdr), .OSC_EN(osc),
    .PWR_CTRL(pc), .WAKE_CLK(wck), .MODE(mode), .SYS_RESET_REQ(srr));
  lpc_core_mdl core (.clk(clk), .go(go), .kind(kind), .wait_int(wint), .wait_evt(wevt),
    .isr(isr));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus, entry and wake tasks.
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  // The request is held until pready is seen high at an edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rd = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task enter(input logic [31:0] c, input logic dp, input logic [1:0] k, input logic [2:0] m);
    apb(1'b1, lpc_pkg::LPC_CTRL_OFS, c);
    deep <= dp;
    kind <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("mode", 32'(m), 32'(mode));
  endtask
  // Waits boundedly for run mode, then checks the wake pulses and clock choice.
  task wake(input logic [1:0] ck, input logic rr);
    repeat (20) begin
      @(posedge clk);
      #1;
      if (mode === lpc_pkg::LPC_RUN) break;
    end
    chk("cpuwake", 32'h1, 32'(cw));
    chk("rstreq", 32'(rr), 32'(srr));
    chk("wakeclk", 32'(ck), 32'(wck));
    @(posedge clk);
    {irq, evt, rtc, tmp, wdw, wdr, ahr, pirq, pin} <= '0;
    rpb <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task conclude();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end

  // Main sequence: reset, bus, sleep, stop, standby and shutdown.
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, lpc_pkg::LPC_CTRL_OFS, 32'h0);
    chk("ctrl", lpc_pkg::LPC_CTRL_RST, rd);
    chk("run", 32'(lpc_pkg::LPC_RUN), 32'(mode));
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, 32'(e));
    enter(32'h0, 1'b0, 2'h0, lpc_pkg::LPC_SLEEP);
    chk("sleeposc", 32'h7F, 32'(osc));
    @(posedge clk) irq <= 1'b1;
    wake(lpc_pkg::LPC_CLK_KEEP, 1'b0);
    enter(32'h0, 1'b0, 2'h1, lpc_pkg::LPC_SLEEP);
    @(posedge clk) evt <= 1'b1;
    wake(lpc_pkg::LPC_CLK_KEEP, 1'b0);
    for (int i = 0; i < 3; i++) begin
      enter(32'(i + 8 * (i % 2)), 1'b1, 2'h2, lpc_pkg::lpc_mode_t'(3'(i + 2)));
      chk("stoposc", 32'h03, 32'(osc));
      chk("regmain", 32'(i == 0), 32'(pc.reg_main));
      chk("retain", 32'(i == 2), 32'(pc.main_core_domain_retain));
      @(posedge clk) ahr <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("hsireq", 32'h1, 32'(osc.internal_16mhz_osc));
      @(posedge clk);
      // Stop 2 is left through a wake pin edge, the others through a peripheral.
      if (i == 2) begin
        pin <= 2'h2;
      end else begin
        pirq <= 8'h80;
      end
      wake(2'(2 - i % 2), 1'b0);
    end
    apb(1'b0, lpc_pkg::LPC_STAT_OFS, 32'h0);
    chk("cause", 32'(lpc_pkg::LPC_CAUSE_PIN) << lpc_pkg::LPC_STAT_CAUSE_LSB, rd);
    enter(32'h3, 1'b1, 2'h0, lpc_pkg::LPC_STOP3);
    @(posedge clk) pirq <= 8'h01;
    repeat (6) @(posedge clk);
    #1;
    chk("stop3", 32'(lpc_pkg::LPC_STOP3), 32'(mode));
    @(posedge clk) rtc <= 1'b1;
    wake(lpc_pkg::LPC_CLK_MULTI_CAP48, 1'b0);
    for (int k = 0; k < 3; k++) begin
      enter({rs[k], 4'(rs[k] == 3'h7 ? 5 : 4)}, 1'b1, 2'h1, lpc_pkg::LPC_STBY);
      chk("sram2", 32'(rs[k]), 32'(pc.sram2_retain));
      chk("reg", 32'(rs[k] != 3'h0), 32'({pc.reg_main, pc.reg_low_power}));
      chk("stbyosc", 32'h03, 32'(osc));
      chk("brownout", 32'h1, 32'(pc.brownout_reset));
      @(posedge clk);
      // The full-retention pass leaves through the external reset pin.
      if (k == 1) begin
        rpb <= 1'b0;
      end else begin
        wdw <= 1'b1;
      end
      wake(lpc_pkg::LPC_CLK_MULTI_12, 1'b1);
    end
    enter(32'h7, 1'b1, 2'h1, lpc_pkg::LPC_SHDN);
    chk("shdnosc", 32'h01, 32'(osc));
    chk("mon", 32'h0, 32'({pc.brownout_reset, pc.supply_monitor, pc.backup_switch}));
    @(posedge clk) wdr <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("shdn", 32'(lpc_pkg::LPC_SHDN), 32'(mode));
    @(posedge clk) tmp <= 1'b1;
    wake(lpc_pkg::LPC_CLK_MULTI_12, 1'b1);
    conclude();
  end
endmodule
